// ==== rtl/dbc_pkg.sv ====
// Shared constants and types for the buffered converter data control block
package dbc_pkg;

  // Register word indices; the byte address is four times the index
  localparam int          IDX_W          = 6;
  localparam int          ADDR_W         = IDX_W + 2;
  localparam logic [5:0]  IDX_CTRL_A     = 6'h00;
  localparam logic [5:0]  IDX_CONTROL_B  = 6'h01;
  localparam logic [5:0]  IDX_EVCTRL     = 6'h02;
  localparam logic [5:0]  IDX_IRQ_EN_CLR = 6'h04;
  localparam logic [5:0]  IDX_IRQ_EN_SET = 6'h05;
  localparam logic [5:0]  IDX_IRQ_FLAGS  = 6'h06;
  localparam logic [5:0]  IDX_SYNC_STAT  = 6'h07;
  localparam logic [5:0]  IDX_CONV_VAL   = 6'h08;
  localparam logic [5:0]  IDX_NEXT_BUF   = 6'h0C;

  // Field positions
  localparam int CA_SOFT_RESET  = 0;
  localparam int CA_ENABLE      = 1;
  localparam int CA_RUN_STANDBY = 2;
  localparam int CB_LEFT_ADJUST = 2;
  localparam int EV_START_IN    = 0;
  localparam int EV_EMPTY_OUT   = 1;
  localparam int ST_SYNC_BUSY   = 7;

  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] DATA_RST = 16'h0000;

  // Domain crossing latency of synchronized registers
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_TIME_NS  = 30;
  localparam int SYNC_CYCLES   = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Sample geometry
  localparam int SAMPLE_W   = 10;
  localparam int LEFT_SHIFT = 6;

  // Interrupt source bits, same layout in enable and flag registers
  typedef struct packed {
    logic sync_ready;
    logic empty;
    logic underrun;
  } dbc_irq_t;

  localparam dbc_irq_t IRQ_RST = '{sync_ready: 1'b0, empty: 1'b0, underrun: 1'b0};

  typedef enum logic {SYNC_IDLE, SYNC_RUN} dbc_sync_state_t;

endpackage : dbc_pkg

// ==== rtl/dbc_dac_ctrl.sv ====
// Buffered sample control for a 10-bit converter, with APB register slave
//
// What this block does
// - Enabled start event loads buffer, starts conversion
// - Enable-clear write of 1 clears enable
// - Buffer-empty enable cleared through enable-clear register
// - Set and clear registers share one enable
// - Enable-set write of 1 sets enable
// - Buffer-empty flag set on buffer transfer
// - Empty flag cleared by 1 or buffer write
// - Interrupt when any flag and enable set
// - Underrun flag set on event, buffer empty
// - Underrun flag cleared only by writing 1
// - Writing 0 leaves flags and enables unchanged
// - Status bit 7 shows synchronization busy
// - Left adjust picks bits 15:6 or 9:0
// - Conversion value write synchronized, protection-blocked
// - Buffer register holds next sample, synchronized
// - Enable-clear bit 2 disables sync-ready interrupt
// - Buffer-empty event out when enabled
// - Left adjust applies to both data registers
// - Soft reset restores all but bus and output flops, discards write
//
// Register map (byte address = word index x 4)
//   0x00 control A: soft reset, enable, run in standby
//   0x04 control B: left adjust in bit 2
//   0x08 event control: start input, empty output
//   0x10 interrupt enable clear, write 1 clears
//   0x14 interrupt enable set, write 1 sets
//   0x18 interrupt flags, write 1 clears
//   0x1C sync status, busy in bit 7
//   0x20 conversion value, write only
//   0x30 next sample buffer, write only
//   Others answer with pslverr
// Interrupt bits: 0 underrun, 1 buffer empty, 2 sync ready
//
// Bus timing
//   One wait state; pready stands one cycle
//   Read data valid only while pready is high
//   Locked writes refused, except buffer and status
//
// Crossing
//   Control A, value and buffer writes set busy
//   Busy lasts SYNC_LEN cycles; data lands on the last
//   A write while busy replaces the pending value
//   Hence software polls busy between such writes
//
// Limitations
//   pready freezes with clk_en; no completion while low
//   Start events come from this clock; no synchronizer
//
// Register access over APB was decided locally.
`timescale 1ns/10ps

module dbc_dac_ctrl
  import dbc_pkg::*;
#(
  parameter int SYNC_LEN = SYNC_CYCLES
) (
  // Clock, reset, freeze
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Access protection lock
  input  wire logic                write_lock,
  // Event system
  input  wire logic                start_event_in,
  output logic                     empty_event_out,
  // Converter side
  output logic      [SAMPLE_W-1:0] dac_sample,
  output logic                     dac_enable,
  output logic                     irq
);

  // Register state
  logic                  enable_reg;
  logic                  enable_active_reg;
  logic                  run_standby_reg;
  logic [7:0]            control_b_reg;
  logic                  start_event_input_enable_reg;
  logic                  buffer_empty_event_output_enable_reg;
  dbc_irq_t              irq_en_reg;
  dbc_irq_t              irq_flags_reg;
  logic [15:0]           conv_value_reg;
  logic [15:0]           next_sample_buffer_reg;
  logic                  buffer_full_reg;
  // Writes waiting for the synchronizer
  logic [15:0]           pend_conv_reg;
  logic                  pend_conv_v_reg;
  logic [15:0]           pend_buf_reg;
  logic                  pend_buf_v_reg;
  logic                  pend_enable_reg;
  logic                  pend_soft_reset_reg;
  dbc_sync_state_t       sync_state_reg;
  logic [7:0]            sync_cnt_reg;
  // Bus pipeline
  logic                  err_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  // Output flops
  logic [SAMPLE_W-1:0]   dac_sample_reg;
  logic                  empty_event_reg;
  logic                  irq_reg;

  // Decode and helpers
  logic [IDX_W-1:0]      idx;
  logic                  mapped;
  logic                  is_protected;
  logic [31:0]           rdata_next;
  logic                  err_next;
  logic                  access_first;
  logic                  wr_ok;
  logic                  sync_done;
  logic                  soft_clear;
  logic                  convert_ev;
  logic                  transfer;
  dbc_irq_t              wr_bits;

  // Bus decode and event qualifiers
  assign idx          = paddr[ADDR_W-1:2];
  assign wr_bits      = dbc_irq_t'(pwdata[2:0]);
  assign access_first = psel & penable & ~pready_reg;
  assign wr_ok        = psel & penable & pready_reg & pwrite & ~err_reg;
  assign sync_done    = (sync_state_reg == SYNC_RUN) && (sync_cnt_reg == 8'h01);
  // Gated so a frozen block cannot be soft reset
  assign soft_clear   = sync_done & pend_soft_reset_reg & clk_en;
  assign convert_ev   = start_event_in & start_event_input_enable_reg
                        & enable_active_reg;
  assign transfer     = convert_ev & buffer_full_reg;

  // Address decode, read mux and error check
  always_comb begin
    mapped       = 1'b1;
    is_protected = 1'b1;
    rdata_next   = 32'h0000_0000;
    case (idx)
      IDX_CTRL_A: begin
        rdata_next[CA_SOFT_RESET]  = pend_soft_reset_reg;
        rdata_next[CA_ENABLE]      = enable_reg;
        rdata_next[CA_RUN_STANDBY] = run_standby_reg;
      end
      IDX_CONTROL_B: begin
        rdata_next[7:0] = control_b_reg;
      end
      IDX_EVCTRL: begin
        rdata_next[EV_START_IN]  = start_event_input_enable_reg;
        rdata_next[EV_EMPTY_OUT] = buffer_empty_event_output_enable_reg;
      end
      IDX_IRQ_EN_CLR, IDX_IRQ_EN_SET: begin
        rdata_next[2:0] = irq_en_reg;
      end
      IDX_IRQ_FLAGS: begin
        rdata_next[2:0] = irq_flags_reg;
      end
      IDX_SYNC_STAT: begin
        is_protected              = 1'b0;
        rdata_next[ST_SYNC_BUSY]  = (sync_state_reg == SYNC_RUN);
      end
      IDX_CONV_VAL: begin
        rdata_next = 32'h0000_0000; // Write-only
      end
      IDX_NEXT_BUF: begin
        is_protected = 1'b0;
        rdata_next   = 32'h0000_0000; // Write-only
      end
      default: begin
        mapped       = 1'b0;
        is_protected = 1'b0;
      end
    endcase
    // Misaligned, unmapped, or locked writes answer with an error
    err_next = ~mapped | (paddr[1:0] != 2'b00)
               | (pwrite & is_protected & write_lock);
  end

  // APB answer: one wait state, then ready with data or error
  // Frozen with clk_en like all other state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      err_reg     <= 1'b0;
    end else if (clk_en) begin
      pready_reg  <= access_first;
      pslverr_reg <= access_first & err_next;
      prdata_reg  <= (access_first & ~pwrite & ~err_next) ? rdata_next : 32'h0000_0000;
      err_reg     <= access_first & err_next;
    end
  end

  // Control A: enable reads back at once, takes effect after sync
  always_ff @(posedge clock) begin
    if (!rst_n || soft_clear) begin
      enable_reg          <= 1'b0;
      run_standby_reg     <= 1'b0;
      enable_active_reg   <= 1'b0;
      pend_enable_reg     <= 1'b0;
      pend_soft_reset_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_ok && idx == IDX_CTRL_A) begin
        if (pwdata[CA_SOFT_RESET]) begin
          pend_soft_reset_reg <= 1'b1;
        end else begin
          enable_reg      <= pwdata[CA_ENABLE];
          pend_enable_reg <= pwdata[CA_ENABLE];
          run_standby_reg <= pwdata[CA_RUN_STANDBY];
        end
      end
      if (sync_done) begin
        enable_active_reg <= pend_enable_reg;
      end
    end
  end

  // Control B and event control; control B is locked while enabled
  always_ff @(posedge clock) begin
    if (!rst_n || soft_clear) begin
      control_b_reg                        <= CTRL_RST;
      start_event_input_enable_reg         <= 1'b0;
      buffer_empty_event_output_enable_reg <= 1'b0;
    end else if (clk_en) begin
      if (wr_ok && idx == IDX_CONTROL_B && !enable_reg) begin
        control_b_reg <= pwdata[7:0];
      end
      if (wr_ok && idx == IDX_EVCTRL) begin
        start_event_input_enable_reg         <= pwdata[EV_START_IN];
        buffer_empty_event_output_enable_reg <= pwdata[EV_EMPTY_OUT];
      end
    end
  end

  // Interrupt enables, one state behind both set and clear views
  always_ff @(posedge clock) begin
    if (!rst_n || soft_clear) begin
      irq_en_reg <= IRQ_RST;
    end else if (clk_en) begin
      if (wr_ok && idx == IDX_IRQ_EN_CLR) begin
        irq_en_reg <= irq_en_reg & ~wr_bits;
      end else if (wr_ok && idx == IDX_IRQ_EN_SET) begin
        irq_en_reg <= irq_en_reg | wr_bits;
      end
    end
  end

  // Interrupt flags; a hardware set beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (!rst_n || soft_clear) begin
      irq_flags_reg <= IRQ_RST;
    end else if (clk_en) begin
      if (wr_ok && idx == IDX_IRQ_FLAGS) begin
        irq_flags_reg <= irq_flags_reg & ~wr_bits;
      end
      if (wr_ok && idx == IDX_NEXT_BUF) begin
        irq_flags_reg.empty <= 1'b0;
      end
      if (transfer) begin
        irq_flags_reg.empty <= 1'b1;
      end
      if (convert_ev && !buffer_full_reg) begin
        irq_flags_reg.underrun <= 1'b1;
      end
      if (sync_done) begin
        irq_flags_reg.sync_ready <= 1'b1;
      end
    end
  end

  // Pending data writes wait here until the crossing completes
  always_ff @(posedge clock) begin
    if (!rst_n || soft_clear) begin
      pend_conv_reg   <= DATA_RST;
      pend_conv_v_reg <= 1'b0;
      pend_buf_reg    <= DATA_RST;
      pend_buf_v_reg  <= 1'b0;
    end else if (clk_en) begin
      if (sync_done) begin
        pend_conv_v_reg <= 1'b0;
        pend_buf_v_reg  <= 1'b0;
      end
      // A write during a busy crossing replaces the pending value
      if (wr_ok && idx == IDX_CONV_VAL) begin
        pend_conv_reg   <= pwdata[15:0];
        pend_conv_v_reg <= 1'b1;
      end
      if (wr_ok && idx == IDX_NEXT_BUF) begin
        pend_buf_reg   <= pwdata[15:0];
        pend_buf_v_reg <= 1'b1;
      end
    end
  end

  // Crossing sequencer: busy from the write until the data lands
  always_ff @(posedge clock) begin
    if (!rst_n || soft_clear) begin
      sync_state_reg <= SYNC_IDLE;
      sync_cnt_reg   <= 8'h00;
    end else if (clk_en) begin
      // Every synchronized write reloads the full count
      if (wr_ok && (idx == IDX_CTRL_A || idx == IDX_CONV_VAL || idx == IDX_NEXT_BUF)) begin
        sync_state_reg <= SYNC_RUN;
        sync_cnt_reg   <= 8'(SYNC_LEN);
      end else begin
        case (sync_state_reg)
          SYNC_IDLE: begin
            sync_cnt_reg <= 8'h00;
          end
          SYNC_RUN: begin
            if (sync_done) begin
              sync_state_reg <= SYNC_IDLE;
            end
            sync_cnt_reg <= sync_cnt_reg - 8'h01;
          end
          default: begin
            sync_state_reg <= SYNC_IDLE;
          end
        endcase
      end
    end
  end

  // Converter-domain data path; a buffer transfer wins over a landing value write, a landing buffer write still refills
  always_ff @(posedge clock) begin
    if (!rst_n || soft_clear) begin
      conv_value_reg         <= DATA_RST;
      next_sample_buffer_reg <= DATA_RST;
      buffer_full_reg        <= 1'b0;
    end else if (clk_en) begin
      if (sync_done && pend_conv_v_reg) begin
        conv_value_reg <= pend_conv_reg;
      end
      if (transfer) begin
        conv_value_reg  <= next_sample_buffer_reg;
        buffer_full_reg <= 1'b0;
      end
      if (sync_done && pend_buf_v_reg) begin
        next_sample_buffer_reg <= pend_buf_reg;
        buffer_full_reg        <= 1'b1;
      end
    end
  end

  // Registered outputs toward converter, event system and CPU
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dac_sample_reg  <= '0;
      empty_event_reg <= 1'b0;
      irq_reg         <= 1'b0;
    end else if (clk_en) begin
      // Same adjust applies to the buffer since it lands here unchanged
      dac_sample_reg  <= control_b_reg[CB_LEFT_ADJUST]
                         ? conv_value_reg[15:LEFT_SHIFT]
                         : conv_value_reg[SAMPLE_W-1:0];
      empty_event_reg <= transfer & buffer_empty_event_output_enable_reg;
      irq_reg         <= |(irq_flags_reg & irq_en_reg);
    end
  end

  // Output wiring; each output is a flop
  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign empty_event_out = empty_event_reg;
  assign dac_sample      = dac_sample_reg;
  assign dac_enable      = enable_active_reg;
  assign irq             = irq_reg;

endmodule : dbc_dac_ctrl

// ==== verif/dbc_dac_ctrl_asserts.sv ====
// Port checks for the converter control block
`timescale 1ns/10ps
module dbc_ctrl_chk
  import dbc_pkg::*;
#(
  parameter int SYNC_LEN = SYNC_CYCLES
) (
  // Clock and reset
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                clk_en,
  // APB
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // Lock, events, converter
  input wire logic                write_lock,
  input wire logic                start_event_in,
  input wire logic                empty_event_out,
  input wire logic [SAMPLE_W-1:0] dac_sample,
  input wire logic                dac_enable,
  input wire logic                irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Answer comes one cycle after the first access edge
  apb_answer_a: assert property (psel && !penable && clk_en ##1 psel && penable && clk_en
    |=> pready) else $error("late or missing pready");
  ready_pulse_a: assert property (pready && clk_en |=> !pready) else $error("pready held");
  err_paired_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stray read data");
  // Locked write to the protected conversion value is refused
  lock_refuse_a: assert property (
    psel && penable && pwrite && write_lock && !pready && clk_en && paddr == 8'h20
    |=> pslverr) else $error("locked write accepted");
  buf_open_a: assert property (
    pready && pwrite && (paddr == 8'h30 || paddr == 8'h1C) |-> !pslverr)
    else $error("unprotected write refused");
  // A frozen cycle keeps the pulse, so only enabled cycles count
  evt_cause_a: assert property (
    empty_event_out && $past(clk_en) |-> $past(start_event_in) && dac_enable)
    else $error("empty event without start");
  // Without a fresh start event the pulse lasts one cycle
  evt_single_a: assert property (
    empty_event_out && !start_event_in && clk_en |=> !empty_event_out)
    else $error("empty event held");
  evt_ignored_a: assert property (
    !dac_enable && start_event_in |=> !empty_event_out)
    else $error("event acted while disabled");
  // Reset is checked with its own disable left open
  reset_clear_a: assert property (
    disable iff (1'b0) !rst_n && clk_en |=> !irq && !dac_enable && !pready)
    else $error("outputs live in reset");

  cover property (empty_event_out);
  cover property (pslverr);
  cover property (irq);
endmodule : dbc_ctrl_chk

// ==== verif/dbc_evt_src.sv ====
// Event system stand-in: start pulses on request, counts empty events
`timescale 1ns/10ps
module dbc_evt_src (
  // Clock
  input  wire logic clock,
  // Bench request, one pulse per toggle
  input  wire logic fire_tgl,
  // Event lines
  output logic      start_event_in,
  input  wire logic empty_event_out,
  output int        empty_seen
);
  logic last_tgl;

  initial begin
    start_event_in = 1'b0;
    empty_seen = 0;
    last_tgl = 1'b0;
  end
  // Single-cycle pulse, as a real channel delivers
  always @(posedge clock) begin
    start_event_in <= (fire_tgl != last_tgl);
    last_tgl <= fire_tgl;
    if (empty_event_out) begin
      empty_seen <= empty_seen + 1;
    end
  end
endmodule : dbc_evt_src

// ==== verif/dbc_dac_ctrl_tb_top.sv ====
// Bench for the converter control block
`timescale 1ns/10ps
module dbc_dac_ctrl_tb_top;
  import dbc_pkg::*;
  // Longer crossing so busy is seen on a read
  localparam int SL = 6;
  logic                clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1;
  logic                psel = 1'b0, penable = 1'b0, pwrite = 1'b0, write_lock = 1'b0;
  logic [ADDR_W-1:0]   paddr = '0;
  logic [31:0]         pwdata = '0, prdata, r;
  logic                pready, pslverr, start_event_in, empty_event_out, dac_enable, irq, e;
  logic [SAMPLE_W-1:0] dac_sample;
  logic                fire_tgl = 1'b0;
  logic [7:0]          ra [6] = '{8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h30};
  int                  empty_seen, err_count = 0, num_checks = 0;

  always #5 clock = ~clock;

  dbc_dac_ctrl #(.SYNC_LEN(SL)) i_dbc_dac_ctrl (.clock(clock), .rst_n(rst_n),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_lock(write_lock), .start_event_in(start_event_in),
    .empty_event_out(empty_event_out), .dac_sample(dac_sample), .dac_enable(dac_enable),
    .irq(irq));
  dbc_evt_src i_dbc_evt_src (.clock(clock), .fire_tgl(fire_tgl),
    .start_event_in(start_event_in), .empty_event_out(empty_event_out),
    .empty_seen(empty_seen));

  task automatic report_and_stop;
    $display("Checks %0d, errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, want);
    end
  endtask : chk

  // One APB transfer, entered just after a rising edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      err_count++;
      $display("[FAIL] %0t no answer", $time);
      report_and_stop;
    end
    @(posedge clock);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
    xfer(1'b1, a, d);
    chk(32'(e), 32'(xe));
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rd

  // Poll busy with a bound; no new synchronized write before it drops
  task automatic wait_idle;
    int k;
    k = 0;
    do begin
      xfer(1'b0, 8'h1C, 32'h0);
      k++;
    end while (r[ST_SYNC_BUSY] !== 1'b0 && k < 20);
    chk(32'(k < 20), 32'h1);
    if (k >= 20) begin
      report_and_stop;
    end
  endtask : wait_idle

  // Crossing done: ready flag up beside the given flags, then cleared
  task automatic sdone(input logic [31:0] fl);
    wait_idle;
    rd(8'h18, fl | 32'h4);
    wr(8'h18, 32'h4, 1'b0);
  endtask : sdone

  task automatic ev;
    fire_tgl <= ~fire_tgl;
    repeat (4) @(posedge clock);
  endtask : ev

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    foreach (ra[i]) rd(ra[i], 32'h0);
    xfer(1'b0, 8'h0C, 32'h0);
    chk(32'(e), 32'h1);
    wr(8'h14, 32'hF8, 1'b0);
    rd(8'h10, 32'h0);
    wr(8'h14, 32'h3, 1'b0);
    rd(8'h10, 32'h3);
    wr(8'h10, 32'h0, 1'b0);
    rd(8'h14, 32'h3);
    wr(8'h10, 32'h2, 1'b0);
    rd(8'h14, 32'h1);
    wr(8'h14, 32'h4, 1'b0);
    rd(8'h10, 32'h5);
    wr(8'h10, 32'h4, 1'b0);
    rd(8'h14, 32'h1);
    // Sample alignment, set while the converter is off
    wr(8'h20, 32'h355, 1'b0);
    rd(8'h1C, 32'h80);
    sdone(32'h0);
    chk(32'(dac_sample), 32'h355);
    wr(8'h04, 32'h4, 1'b0);
    repeat (2) @(posedge clock);
    chk(32'(dac_sample), 32'h00D);
    wr(8'h20, 32'hD540, 1'b0);
    sdone(32'h0);
    chk(32'(dac_sample), 32'h355);
    write_lock <= 1'b1;
    wr(8'h20, 32'hFFFF, 1'b1);
    wr(8'h30, 32'h4AC0, 1'b0);
    write_lock <= 1'b0;
    sdone(32'h0);
    chk(32'(dac_sample), 32'h355);
    ev;
    chk(32'(empty_seen), 32'h0);
    wr(8'h00, 32'h2, 1'b0);
    sdone(32'h0);
    chk(32'(dac_enable), 32'h1);
    ev;
    rd(8'h18, 32'h0);
    wr(8'h08, 32'h3, 1'b0);
    ev;
    rd(8'h18, 32'h2);
    chk(32'(dac_sample), 32'h12B);
    chk(32'(empty_seen), 32'h1);
    chk(32'(irq), 32'h0);
    ev;
    rd(8'h18, 32'h3);
    chk(32'(irq), 32'h1);
    chk(32'(empty_seen), 32'h1);
    wr(8'h18, 32'h0, 1'b0);
    rd(8'h18, 32'h3);
    wr(8'h30, 32'h8000, 1'b0);
    sdone(32'h1);
    wr(8'h18, 32'h1, 1'b0);
    rd(8'h18, 32'h0);
    chk(32'(irq), 32'h0);
    ev;
    chk(32'(dac_sample), 32'h200);
    // Frozen block ignores an event that would underrun
    clk_en <= 1'b0;
    ev;
    clk_en <= 1'b1;
    wr(8'h14, 32'h2, 1'b0);
    rd(8'h18, 32'h2);
    chk(32'(irq), 32'h1);
    wr(8'h00, 32'h3, 1'b0);
    wait_idle;
    rd(8'h14, 32'h0);
    chk(32'(dac_enable), 32'h0);
    chk(32'(dac_sample), 32'h0);
    report_and_stop;
  end
endmodule : dbc_dac_ctrl_tb_top

bind dbc_dac_ctrl dbc_ctrl_chk #(.SYNC_LEN(SYNC_LEN)) i_dbc_ctrl_chk (.clock(clock),
  .rst_n(rst_n), .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .write_lock(write_lock), .start_event_in(start_event_in),
  .empty_event_out(empty_event_out), .dac_sample(dac_sample), .dac_enable(dac_enable),
  .irq(irq));
